// ===== hw/adcsa_top.sv
// Purpose: Sequencer, SAR logic and accumulator of an 8-bit converter.
// Assumes: comp_i comes from the analogue comparator, asynchronous.
// Notes: Configuration except rate select is latched on a start from idle; restarts reload only the window.
`timescale 1ns/1ps
`default_nettype none
`include "adcsa_cfg.svh"
module adcsa_top
   import adcsa_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic start_i,
   input wire logic cont_i,
   input wire logic [2:0] chan_sel_i,
   input wire logic [1:0] rate_sel_i,
   input wire logic [1:0] samp_sel_i,
   input wire logic gain_i,
   input wire logic vref_ext_i,
   input wire logic acc_en_i,
   input wire logic [1:0] acc_sel_i,
   input wire logic done_clr_i,
   input wire logic comp_i,
   output logic [2:0] chan_o,
   output logic gain_o,
   output logic vref_ext_o,
   output logic track_o,
   output logic supply_div_en_o,
   output logic [7:0] trial_o,
   output logic [7:0] result_o,
   output logic [11:0] acc_sum_o,
   output logic busy_o,
   output logic done_flag_o,
   output logic done_irq_o
);
   // ===============================================================
   // Declarations
   adcsa_seq_t s_reg;
   adcsa_seq_t s_next;
   logic tick;
   logic [5:0] total;
   logic last_conv;
   logic restart;

   // Window in periods is twice the code plus two.
   function automatic logic [3:0] samp_len(input logic [1:0] code);
      samp_len = {1'b0, code, 1'b0} + `ADCSA_RST_SAMP;
   endfunction

   // Accumulation count is two to the code plus one.
   function automatic logic [4:0] acc_count(input logic [1:0] code);
      acc_count = 5'(5'h02 << code);
   endfunction

   // ===============================================================
   // Converter clock
   adcsa_clkdiv u_div (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .run_i(s_reg.st != ADCSA_IDLE),
      .rate_sel_i(rate_sel_i),
      .tick_o(tick)
   );

   // Conversion length in converter periods.
   assign total = 6'(`ADCSA_SAMP_MULT * s_reg.samp + `ADCSA_CONV_EXTRA);
   assign last_conv = !s_reg.acc_en || (s_reg.acc_n + 5'h01 == s_reg.acc_len);
   assign restart = cont_i || !last_conv;

   // ===============================================================
   // Sequencer
   // Loads configuration, tracks, runs the bit trials and accumulates.
   always_comb begin
      s_next = s_reg;
      s_next.irq = 1'b0;
      s_next.comp_m = comp_i;
      s_next.comp_s = s_reg.comp_m;
      s_next.flag = s_reg.flag && !done_clr_i;
      case (s_reg.st)
         ADCSA_IDLE: begin
            if (start_i || cont_i) begin
               s_next.st = ADCSA_TRACK;
               s_next.cnt = 6'h00;
               s_next.samp = samp_len(samp_sel_i);
               s_next.chan = (chan_sel_i > `ADCSA_CHAN_LAST) ? `ADCSA_RST_CHAN : chan_sel_i;
               s_next.gain = gain_i;
               s_next.vref_ext = vref_ext_i;
               s_next.acc_en = acc_en_i;
               s_next.acc_len = acc_count(acc_sel_i);
               s_next.acc = 12'h000;
               s_next.acc_n = 5'h00;
               s_next.trial = 8'h00;
               s_next.sar_idx = `ADCSA_SAR_DONE;
            end
         end
         ADCSA_TRACK: begin
            if (tick) begin
               s_next.cnt = s_reg.cnt + 6'h01;
               if (s_reg.cnt + 6'h01 == {2'h0, s_reg.samp}) begin
                  s_next.st = ADCSA_HOLD;
                  s_next.trial = 8'h80;
                  s_next.sar_idx = 4'h7;
               end
            end
         end
         ADCSA_HOLD: begin
            if (tick) begin
               s_next.cnt = s_reg.cnt + 6'h01;
               // Keep the trial bit when the input is at or above it.
               if (!s_reg.sar_idx[3]) begin
                  s_next.trial[s_reg.sar_idx[2:0]] = s_reg.comp_s;
                  if (s_reg.sar_idx != 4'h0) begin
                     s_next.trial[s_reg.sar_idx[2:0] - 3'h1] = 1'b1;
                  end
                  s_next.sar_idx = s_reg.sar_idx - 4'h1;
               end
               if (s_reg.cnt + 6'h01 == total) begin
                  s_next.result = s_reg.trial;
                  s_next.acc = s_reg.acc + {4'h0, s_reg.trial};
                  s_next.acc_n = s_reg.acc_n + 5'h01;
                  if (last_conv) begin
                     s_next.irq = 1'b1;
                     s_next.flag = 1'b1;
                     s_next.acc_out = s_reg.acc + {4'h0, s_reg.trial};
                     s_next.acc = 12'h000;
                     s_next.acc_n = 5'h00;
                  end
                  s_next.cnt = 6'h00;
                  s_next.trial = 8'h00;
                  s_next.sar_idx = `ADCSA_SAR_DONE;
                  s_next.st = restart ? ADCSA_TRACK : ADCSA_IDLE;
                  if (restart) begin
                     s_next.samp = samp_len(samp_sel_i);
                  end
               end
            end
         end
         default: begin
            s_next.st = ADCSA_IDLE;
         end
      endcase
   end

   // Registers the sequencer state.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_reg <= '0;
         s_reg.samp <= `ADCSA_RST_SAMP;
         s_reg.sar_idx <= `ADCSA_SAR_DONE;
      end else begin
         s_reg <= s_next;
      end
   end

   // ===============================================================
   // Outputs
   assign chan_o = s_reg.chan;
   assign gain_o = s_reg.gain;
   assign vref_ext_o = s_reg.vref_ext;
   assign track_o = (s_reg.st == ADCSA_TRACK);
   assign supply_div_en_o = busy_o && (s_reg.chan == `ADCSA_CHAN_SUPPLY);
   assign trial_o = s_reg.trial;
   assign result_o = s_reg.result;
   assign acc_sum_o = s_reg.acc_out;
   assign busy_o = (s_reg.st != ADCSA_IDLE);
   assign done_flag_o = s_reg.flag;
   assign done_irq_o = s_reg.irq;

   // ===============================================================
   // Checks
   logic [6:0] gap_cnt;
   logic [5:0] conv_ticks;
   logic [6:0] ratio;

   // Counts cycles between ticks and ticks within one conversion.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gap_cnt <= 7'h00;
         conv_ticks <= 6'h00;
      end else begin
         gap_cnt <= (tick || !busy_o) ? 7'h00 : gap_cnt + 7'h01;
         if (!busy_o || (tick && s_reg.st == ADCSA_HOLD && s_reg.cnt + 6'h01 == total)) begin
            conv_ticks <= 6'h00;
         end else if (tick) begin
            conv_ticks <= conv_ticks + 6'h01;
         end
      end
   end
   assign ratio = 7'(`ADCSA_DIV_BASE << rate_sel_i);

   chk_tick_spacing: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      tick && busy_o && $past(busy_o) && $past(tick) == 1'b0 && $stable(rate_sel_i)
      |-> gap_cnt == ratio - 7'h01)
      else $error("converter tick spacing wrong");
   chk_conv_length: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      tick && s_reg.st == ADCSA_HOLD && s_reg.cnt + 6'h01 == total
      |-> conv_ticks + 6'h01 == total)
      else $error("conversion length wrong");
   chk_track_window: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $fell(track_o) && busy_o |-> s_reg.cnt == {2'h0, s_reg.samp})
      else $error("tracking window length wrong");
   chk_samp_legal: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      busy_o |-> (s_reg.samp inside {4'h2, 4'h4, 4'h6, 4'h8}))
      else $error("illegal sampling window");
   chk_chan_range: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      chan_o <= `ADCSA_CHAN_LAST)
      else $error("channel out of range");
   chk_supply_gate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      supply_div_en_o == (busy_o && chan_o == `ADCSA_CHAN_SUPPLY))
      else $error("supply divider on outside measurement");
   chk_start_busy: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      start_i && !busy_o |=> busy_o ##0 track_o)
      else $error("start did not begin conversion");
   chk_irq_result: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      done_irq_o |-> done_flag_o && result_o == $past(trial_o))
      else $error("completion without status or result");
   chk_irq_once: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $rose(s_reg.acc_n != 5'h00) |-> !done_irq_o)
      else $error("completion signalled mid accumulation");
   chk_acc_sum: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      done_irq_o && s_reg.acc_en |-> acc_sum_o == $past(s_reg.acc) + {4'h0, result_o})
      else $error("accumulated sum wrong");
endmodule
`default_nettype wire

// ===== hw/adcsa_cfg.svh
// Purpose: Constants for the converter sequencer and accumulator.
// Assumes: ref_clk_i is the converter source clock.
// Notes: Times are in converter clock periods unless stated.
`ifndef ADCSA_CFG_SVH
`define ADCSA_CFG_SVH
// ==================================================================
// Clocking
`define ADCSA_SRC_HZ 16000000
`define ADCSA_CONV_MAX_HZ 2000000
`define ADCSA_DIV_BASE (`ADCSA_SRC_HZ / `ADCSA_CONV_MAX_HZ)
`define ADCSA_DIV_W 7
// ==================================================================
// Conversion timing
`define ADCSA_SAMP_MULT 3
`define ADCSA_CONV_EXTRA 10
`define ADCSA_RES_W 8
`define ADCSA_ACC_W 12
// ==================================================================
// Channels
`define ADCSA_CHAN_TEMP 3'h4
`define ADCSA_CHAN_SUPPLY 3'h5
`define ADCSA_CHAN_LAST 3'h5
// ==================================================================
// Reset values
`define ADCSA_RST_SAMP 4'h2
`define ADCSA_RST_CHAN 3'h0
`define ADCSA_SAR_DONE 4'hf
`endif

// ===== hw/adcsa_pkg.sv
// Purpose: Types for the converter sequencer and accumulator.
// Assumes: Constants come from adcsa_cfg.svh.
// Notes: States use Gray codes along idle, track, hold.
package adcsa_pkg;
   // ===============================================================
   // Sequencer states
   typedef enum logic [1:0] {
      ADCSA_IDLE = 2'h0,
      ADCSA_TRACK = 2'h1,
      ADCSA_HOLD = 2'h3
   } adcsa_state_t;

   // ===============================================================
   // Divider state
   typedef struct packed {
      logic [6:0] cnt;
   } adcsa_div_t;

   // ===============================================================
   // Sequencer state
   typedef struct packed {
      adcsa_state_t st;
      logic [5:0] cnt;
      logic [3:0] samp;
      logic [3:0] sar_idx;
      logic [7:0] trial;
      logic [7:0] result;
      logic [11:0] acc;
      logic [11:0] acc_out;
      logic [4:0] acc_n;
      logic [4:0] acc_len;
      logic acc_en;
      logic [2:0] chan;
      logic gain;
      logic vref_ext;
      logic flag;
      logic irq;
      logic comp_m;
      logic comp_s;
   } adcsa_seq_t;
endpackage

// ===== hw/adcsa_clkdiv.sv
// Purpose: Converter clock divider, one-cycle tick per converter period.
// Assumes: Runs only while a conversion is in progress.
// Notes: Ratio is the base divide shifted by the rate select.
`timescale 1ns/1ps
`default_nettype none
`include "adcsa_cfg.svh"
module adcsa_clkdiv
   import adcsa_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic run_i,
   input wire logic [1:0] rate_sel_i,
   output logic tick_o
);
   // ===============================================================
   // Counter
   adcsa_div_t s_reg;
   adcsa_div_t s_next;
   logic [6:0] last;

   // Terminal count is ratio minus one; ratio is 8, 16, 32 or 64.
   assign last = 7'((`ADCSA_DIV_BASE << rate_sel_i) - 1);
   assign tick_o = run_i && (s_reg.cnt == last);

   // The count restarts whenever the sequencer stops.
   always_comb begin
      s_next = s_reg;
      if (!run_i || tick_o) begin
         s_next.cnt = 7'h00;
      end else begin
         s_next.cnt = s_reg.cnt + 7'h01;
      end
   end

   // Registers the divider state.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule
`default_nettype wire

// ===== verif/adcsa_comp_model.sv
// Purpose: Analogue comparator and input mux seen by the sequencer.
// Assumes: Each channel holds a fixed input level.
// Notes: slow_i delays the comparator answer by one cycle.
`timescale 1ns/1ps
`default_nettype none
module adcsa_comp_model (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic [2:0] chan_i,
   input wire logic gain_i,
   input wire logic [7:0] trial_i,
   input wire logic slow_i,
   output logic comp_o
);
   // ===============================================================
   // Comparator
   logic [7:0] lvl;
   logic hit, hit_reg;
   // Channel level as a code; the doubled range halves it.
   assign lvl = (8'h17 + 8'h29 * {5'h0, chan_i}) >> gain_i;
   assign hit = lvl >= trial_i;
   // Lagged answer for the slow comparator case.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i)
         hit_reg <= 1'b0;
      else
         hit_reg <= hit;
   end
   assign comp_o = slow_i ? hit_reg : hit;
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: The comparator model holds one level per channel.
// Notes: Durations are counted in reference clock cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ===============================================================
   // Signals
   logic ref_clk_i, nrst_i, start_i, cont_i, gain_i, vref_ext_i, acc_en_i;
   logic done_clr_i, comp, slow, gain_o, vref_ext_o, track_o, sup_o;
   logic busy_o, done_flag_o, done_irq_o;
   logic [2:0] chan_sel_i, chan_o;
   logic [1:0] rate_sel_i, samp_sel_i, acc_sel_i;
   logic [7:0] trial_o, result_o;
   logic [11:0] acc_sum_o;
   int n_mismatch, checks, nb, nt, ni, ns;
   // ===============================================================
   // Design and comparator model
   adcsa_top i_adcsa_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .start_i(start_i),
      .cont_i(cont_i), .chan_sel_i(chan_sel_i), .rate_sel_i(rate_sel_i),
      .samp_sel_i(samp_sel_i), .gain_i(gain_i), .vref_ext_i(vref_ext_i),
      .acc_en_i(acc_en_i), .acc_sel_i(acc_sel_i), .done_clr_i(done_clr_i), .comp_i(comp),
      .chan_o(chan_o), .gain_o(gain_o), .vref_ext_o(vref_ext_o), .track_o(track_o),
      .supply_div_en_o(sup_o), .trial_o(trial_o), .result_o(result_o),
      .acc_sum_o(acc_sum_o), .busy_o(busy_o), .done_flag_o(done_flag_o),
      .done_irq_o(done_irq_o));
   adcsa_comp_model i_adcsa_comp_model (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .chan_i(chan_o), .gain_i(gain_o), .trial_i(trial_o), .slow_i(slow), .comp_o(comp));
   // Reference clock, 50 ns period.
   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   // ===============================================================
   // Compare and drive tasks
   task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic rng(input string w, input int e, input int g, input int tol);
      checks++;
      if (g < e - tol || g > e + tol) begin
         n_mismatch++;
         $display("FAIL %s expected %0d seen %0d", w, e, g);
      end
   endtask
   // Input code of a channel as the comparator model sees it.
   function automatic logic [7:0] code(input logic [2:0] ch);
      logic [2:0] c;
      c = (ch > 3'h5) ? 3'h0 : ch;
      return (8'h17 + 8'h29 * {5'h0, c}) >> c[0];
   endfunction
   // Counts busy, track, pulse and supply cycles until busy drops.
   task automatic watch(input int stop);
      nb = 0;
      nt = 0;
      ni = 0;
      ns = 0;
      for (int k = 0; k < 9000; k++) begin
         @(negedge ref_clk_i);
         ni += int'(done_irq_o === 1'b1);
         ns += int'(sup_o === 1'b1);
         if (busy_o !== 1'b1) break;
         nb++;
         nt += int'(track_o === 1'b1);
         @(posedge ref_clk_i);
         if (ni >= stop) cont_i <= 1'b0;
      end
      chk("watch limit", 16'h0, 16'(nb >= 9000));
   endtask
   task automatic conv(input logic [2:0] ch, input logic [1:0] sp, input logic [1:0] rt,
         input logic ac, input logic [1:0] as, input int stop);
      @(posedge ref_clk_i);
      chan_sel_i <= ch;
      samp_sel_i <= sp;
      rate_sel_i <= rt;
      acc_en_i <= ac;
      acc_sel_i <= as;
      gain_i <= ch[0];
      vref_ext_i <= ch[1];
      slow <= ch[2];
      start_i <= 1'b1;
      cont_i <= stop > 0;
      @(posedge ref_clk_i);
      start_i <= 1'b0;
      watch(stop);
   endtask
   // ===============================================================
   // Scenarios
   task automatic t_single();
      int s;
      for (int ch = 0; ch < 7; ch++) begin
         conv(3'(ch), 2'(ch), 2'h0, 1'b0, 2'h0, 0);
         s = 2 * (ch % 4 + 1);
         rng("conv cycles", (3 * s + 10) * 8, nb, 2);
         rng("track cycles", s * 8, nt, 2);
         chk("result", 16'(code(3'(ch))), 16'(result_o));
         chk("channel", 16'(ch > 5 ? 0 : ch), 16'(chan_o));
         chk("range ref", 16'({ch[0], ch[1]}), 16'({gain_o, vref_ext_o}));
         chk("pulses", 16'h1, 16'(ni));
         chk("flag", 16'h1, 16'(done_flag_o));
         chk("supply", 16'(ch == 5 ? nb : 0), 16'(ns));
         @(posedge ref_clk_i);
         done_clr_i <= 1'b1;
         @(posedge ref_clk_i);
         done_clr_i <= 1'b0;
         @(negedge ref_clk_i);
         chk("flag clear", 16'h0, 16'(done_flag_o));
      end
      $display("single done");
   endtask
   task automatic t_rates();
      for (int rt = 1; rt < 4; rt++) begin
         conv(3'h3, 2'h0, 2'(rt), 1'b0, 2'h0, 0);
         rng("rate cycles", 16 * (8 << rt), nb, 3);
         chk("rate result", 16'(code(3'h3)), 16'(result_o));
      end
      $display("rates done");
   endtask
   task automatic t_refuse();
      conv(3'h4, 2'h0, 2'h0, 1'b0, 2'h0, 0);
      @(posedge ref_clk_i);
      start_i <= 1'b1;
      @(posedge ref_clk_i);
      start_i <= 1'b0;
      repeat (30) @(posedge ref_clk_i);
      start_i <= 1'b1;
      chan_sel_i <= 3'h1;
      @(posedge ref_clk_i);
      start_i <= 1'b0;
      watch(0);
      rng("refused start", 128 - 32, nb, 3);
      chk("refused chan", 16'h4, 16'(chan_o));
      chk("refused pulses", 16'h1, 16'(ni));
      $display("refuse done");
   endtask
   task automatic t_cont();
      conv(3'h2, 2'h0, 2'h0, 1'b0, 2'h0, 2);
      chk("cont pulses", 16'h3, 16'(ni));
      rng("cont cycles", 384, nb, 6);
      chk("cont result", 16'(code(3'h2)), 16'(result_o));
      $display("cont done");
   endtask
   task automatic t_acc();
      int n;
      for (int a = 0; a < 4; a++) begin
         conv(3'(a), 2'h0, 2'h0, 1'b1, 2'(a), 0);
         n = 2 << a;
         chk("acc pulses", 16'h1, 16'(ni));
         rng("acc cycles", n * 128, nb, 2 * n);
         chk("acc sum", 16'(n * code(3'(a))), 16'(acc_sum_o));
         chk("acc mean", 16'(code(3'(a))), 16'(acc_sum_o >> (a + 1)));
      end
      $display("acc done");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Main sequence after a reset of six cycles.
   initial begin
      {nrst_i, start_i, cont_i, gain_i, vref_ext_i, acc_en_i, done_clr_i, slow} = 8'h00;
      {chan_sel_i, rate_sel_i, samp_sel_i, acc_sel_i} = 9'h000;
      repeat (6) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      @(negedge ref_clk_i);
      chk("reset", 16'h0, 16'({busy_o, done_flag_o, track_o, sup_o}));
      t_single();
      t_rates();
      t_refuse();
      t_cont();
      t_acc();
      print_verdict();
   end
   // Watchdog well beyond the expected run length.
   initial begin
      repeat (40000) @(posedge ref_clk_i);
      n_mismatch++;
      print_verdict();
   end
endmodule
`default_nettype wire
